//--- core/spwm_pkg.sv
// Purpose: shared constants for the standard single-output pwm block
// Assumes: apb slave, 32-bit data, one word per register
package spwm_pkg;
	localparam int unsigned APB_AW = 8;
	// register byte offsets
	localparam logic [7:0] OFF_TIMER_CONTROL = 8'h00;
	localparam logic [7:0] OFF_PERIOD_LIMIT = 8'h04;
	localparam logic [7:0] OFF_PERIOD_TIMER = 8'h08;
	localparam logic [7:0] OFF_DUTY_UPPER = 8'h0c;
	localparam logic [7:0] OFF_DUTY_SHADOW = 8'h10;
	localparam logic [7:0] OFF_CAPTURE_PWM_CONTROL = 8'h14;
	localparam logic [7:0] OFF_PERIPHERAL_FLAG = 8'h18;
	localparam logic [7:0] OFF_PIN_DIRECTION = 8'h1c;
	// field positions
	localparam int unsigned TC_PS_LSB = 0;
	localparam int unsigned TC_RUN_BIT = 2;
	localparam int unsigned TC_POST_LSB = 3;
	localparam int unsigned CPC_LOW_LSB = 4;
	localparam int unsigned FLAG_MATCH_BIT = 1;
	// reset values
	localparam logic [6:0] RST_TIMER_CONTROL = 7'h00;
	localparam logic [7:0] RST_PERIOD_LIMIT = 8'hff;
	localparam logic [7:0] RST_DUTY_UPPER = 8'h00;
	localparam logic [5:0] RST_CAPTURE_PWM_CONTROL = 6'h00;
	localparam logic RST_PIN_DIRECTION = 1'b1;
	// prescale selections and the last divider count of each
	localparam logic [1:0] PS_DIV1 = 2'h0;
	localparam logic [1:0] PS_DIV4 = 2'h1;
	localparam logic [3:0] PS_LAST1 = 4'h0;
	localparam logic [3:0] PS_LAST4 = 4'h3;
	localparam logic [3:0] PS_LAST16 = 4'hf;
	// capture/pwm mode field: 11xx selects pwm
	localparam logic [1:0] MODE_PWM_TOP = 2'h3;
endpackage

//--- core/spwm_tb_if.sv
// Purpose: carries the time base from the timer to the duty logic
// Assumes: single clock domain
// Notes: tbase holds timer in 9:2 and low phase bits in 1:0
`timescale 1ns/10ps
`default_nettype none
interface spwm_tb_if;
	logic sleep;
	logic adv;
	logic restart;
	logic [9:0] tbase;
	modport src (input sleep, output adv, output restart, output tbase);
	modport snk (input sleep, input adv, input restart, input tbase);
endinterface
`default_nettype wire

//--- core/spwm_timebase.sv
// Purpose: prescaler, low phase bits and 8-bit period timer
// Assumes: pclk is the oscillator clock
// Notes: postscaler is not part of this path
`timescale 1ns/10ps
`default_nettype none
module spwm_timebase
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic run,
	input wire logic [1:0] ps_sel,
	input wire logic [7:0] limit,
	spwm_tb_if.src tb
);
	import spwm_pkg::*;
	logic [3:0] div_r;
	logic [1:0] low_r;
	logic [7:0] timer_r;
	logic [3:0] last;
	logic go;
	logic adv;
	logic restart;

	// ratio 1, 4 or 16; 1:1 makes the low bits the clock phase
	always_comb
	begin
		unique case (ps_sel)
			PS_DIV1: last = PS_LAST1;
			PS_DIV4: last = PS_LAST4;
			default: last = PS_LAST16;
		endcase
	end
	assign go = run && !tb.sleep;
	// >= so a smaller ratio picked mid-count cannot stall the divider
	assign adv = go && (div_r >= last);
	assign restart = adv && (low_r == 2'h3) && (timer_r == limit);

	// prescaler divider
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			div_r <= 4'h0;
		else if (go)
			div_r <= adv ? 4'h0 : div_r + 4'h1;
	end

	// two low time-base bits
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			low_r <= 2'h0;
		else if (adv)
			low_r <= low_r + 2'h1;
	end

	// period timer, cleared on the increment after it meets the limit
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_r <= 8'h00;
		else if (adv && low_r == 2'h3)
			timer_r <= restart ? 8'h00 : timer_r + 8'h01;
	end

	assign tb.adv = adv;
	assign tb.restart = restart;
	assign tb.tbase = {timer_r, low_r};

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence at_limit_s;
		adv && low_r == 2'h3 && timer_r == limit;
	endsequence
	restart_clear_a: assert property (at_limit_s |=> timer_r == 8'h00 && low_r == 2'h0)
		else $error("timer not cleared after limit match");
	sleep_hold_a: assert property (tb.sleep |=> $stable(timer_r) && $stable(low_r))
		else $error("time base moved during sleep");
	ratio_one_a: assert property (go && ps_sel == PS_DIV1 |-> adv)
		else $error("1:1 prescale did not advance every clock");
	ratio_four_a: assert property (go && ps_sel == PS_DIV4 && adv ##1 go && ps_sel == PS_DIV4 |-> !adv)
		else $error("1:4 prescale advanced on consecutive clocks");
endmodule
`default_nettype wire

//--- core/spwm_duty.sv
// Purpose: double-buffered duty value and output level
// Assumes: time base and restart come from the timer module
// Notes: the output level is held by one flop, so it cannot glitch
`timescale 1ns/10ps
`default_nettype none
module spwm_duty
(
	input wire logic pclk,
	input wire logic presetn,
	spwm_tb_if.snk tb,
	input wire logic pwm_mode,
	input wire logic [9:0] duty_next,
	input wire logic sw_wr,
	input wire logic [7:0] sw_data,
	output logic [9:0] shadow,
	output logic level
);
	import spwm_pkg::*;
	logic [9:0] shadow_r;
	logic level_r;

	// shadow byte plus 2-bit latch, loaded at period restart; software can also write the byte outside pwm mode and sleep
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			shadow_r <= 10'h000;
		else if (tb.restart)
			shadow_r <= duty_next;
		else if (sw_wr && !pwm_mode && !tb.sleep)
			shadow_r[9:2] <= sw_data;
	end

	// set at period start, cleared on the step that brings the time base to the duty,
	// so the high time is exactly duty steps and not one clock longer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_r <= 1'b0;
		else if (tb.sleep)
			level_r <= level_r;
		else if (tb.restart)
			level_r <= (duty_next != 10'h000);
		else if (tb.adv && (tb.tbase + 10'h001) == shadow_r)
			level_r <= 1'b0;
	end

	assign shadow = shadow_r;
	assign level = level_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	shadow_load_a: assert property (tb.restart |=> shadow_r == $past(duty_next))
		else $error("shadow duty not loaded at restart");
	shadow_ro_a: assert property (!tb.restart && pwm_mode |=> $stable(shadow_r))
		else $error("shadow changed in pwm mode outside restart");
	out_set_a: assert property (tb.restart && !tb.sleep && duty_next != 10'h000 |=> level_r)
		else $error("output not set at period start");
	out_zero_a: assert property (tb.restart && duty_next == 10'h000 |=> !level_r)
		else $error("zero duty still set the output");
	out_clear_a: assert property (!tb.sleep && !tb.restart && tb.adv && (tb.tbase + 10'h001) == shadow_r |=> !level_r)
		else $error("output not cleared at duty match");
endmodule
`default_nettype wire

//--- core/spwm_top.sv
// Purpose: standard pwm output with apb register access
// Assumes: pclk is the oscillator clock; inputs synchronous to pclk
// Notes: one wait state on every apb access; pin enable is active low
`timescale 1ns/10ps
`default_nettype none
module spwm_top
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [spwm_pkg::APB_AW-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic sleep_i,
	input wire logic pwm_pin_i,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic pwm_pin_o,
	output logic pwm_pin_oe_n
);
	import spwm_pkg::*;

	logic pready_r;
	logic pslverr_r;
	logic [31:0] prdata_r;
	logic [6:0] timer_control_r;
	logic [7:0] period_limit_r;
	logic [7:0] duty_upper_r;
	logic [5:0] capture_pwm_control_r;
	logic timer_match_flag_r;
	logic pin_direction_r;
	logic pin_o_r;
	logic pin_oe_n_r;
	logic pin_seen_r;
	logic access;
	logic commit;
	logic wr;
	logic mapped;
	logic pwm_mode;
	logic [31:0] rd_mux;
	logic [9:0] duty_next;
	logic [9:0] shadow;
	logic level;
	logic shadow_wr;

	spwm_tb_if tb_if ();
	assign tb_if.sleep = sleep_i;

	// timer and prescaler; postscale bits are stored but never routed here
	spwm_timebase u_timebase
	(
		.pclk(pclk),
		.presetn(presetn),
		.run(timer_control_r[TC_RUN_BIT]),
		.ps_sel(timer_control_r[TC_PS_LSB+:2]),
		.limit(period_limit_r),
		.tb(tb_if.src)
	);

	// duty is upper byte over control bits 5:4
	assign duty_next = {duty_upper_r, capture_pwm_control_r[CPC_LOW_LSB+:2]};
	assign pwm_mode = (capture_pwm_control_r[3:2] == MODE_PWM_TOP);
	assign shadow_wr = wr && (paddr == OFF_DUTY_SHADOW);

	spwm_duty u_duty
	(
		.pclk(pclk),
		.presetn(presetn),
		.tb(tb_if.snk),
		.pwm_mode(pwm_mode),
		.duty_next(duty_next),
		.sw_wr(shadow_wr),
		.sw_data(pwdata[7:0]),
		.shadow(shadow),
		.level(level)
	);

	// apb phases: the answer flop rises one clock into the access phase
	assign access = psel && penable;
	assign commit = access && pready_r;
	assign wr = commit && pwrite && mapped;

	// address decode; anything off the map answers with an error
	always_comb
	begin
		mapped = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (paddr)
			OFF_TIMER_CONTROL: rd_mux[6:0] = timer_control_r;
			OFF_PERIOD_LIMIT: rd_mux[7:0] = period_limit_r;
			OFF_PERIOD_TIMER: rd_mux[7:0] = tb_if.tbase[9:2];
			OFF_DUTY_UPPER: rd_mux[7:0] = duty_upper_r;
			OFF_DUTY_SHADOW: rd_mux[7:0] = shadow[9:2];
			OFF_CAPTURE_PWM_CONTROL: rd_mux[5:0] = capture_pwm_control_r;
			OFF_PERIPHERAL_FLAG: rd_mux[FLAG_MATCH_BIT] = timer_match_flag_r;
			OFF_PIN_DIRECTION: rd_mux[0] = pin_direction_r;
			default: mapped = 1'b0;
		endcase
	end

	// ready pulses for exactly one clock per access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready_r <= 1'b0;
		else
			pready_r <= access && !pready_r;
	end

	// read data and error are captured with ready, so both come from flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
		else if (access && !pready_r)
		begin
			prdata_r <= pwrite ? 32'h0000_0000 : rd_mux;
			pslverr_r <= !mapped;
		end
		else
		begin
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
		end
	end

	// timer control: prescale, run and postscale fields
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_control_r <= RST_TIMER_CONTROL;
		else if (wr && paddr == OFF_TIMER_CONTROL)
			timer_control_r <= pwdata[6:0];
	end

	// period limit; a new value is seen by the next compare against the timer
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			period_limit_r <= RST_PERIOD_LIMIT;
		else if (wr && paddr == OFF_PERIOD_LIMIT)
			period_limit_r <= pwdata[7:0];
	end

	// writable duty byte, free to change at any time
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			duty_upper_r <= RST_DUTY_UPPER;
		else if (wr && paddr == OFF_DUTY_UPPER)
			duty_upper_r <= pwdata[7:0];
	end

	// control register: mode in 3:0, duty low bits in 5:4
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			capture_pwm_control_r <= RST_CAPTURE_PWM_CONTROL;
		else if (wr && paddr == OFF_CAPTURE_PWM_CONTROL)
			capture_pwm_control_r <= pwdata[5:0];
	end

	// match flag: a restart in the clearing cycle still leaves it set
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			timer_match_flag_r <= 1'b0;
		else if (tb_if.restart)
			timer_match_flag_r <= 1'b1;
		else if (wr && paddr == OFF_PERIPHERAL_FLAG && pwdata[FLAG_MATCH_BIT])
			timer_match_flag_r <= 1'b0;
	end

	// direction bit: set means input, as after reset
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_direction_r <= RST_PIN_DIRECTION;
		else if (wr && paddr == OFF_PIN_DIRECTION)
			pin_direction_r <= pwdata[0];
	end

	// pin is driven only in pwm mode with the direction bit clear
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			pin_o_r <= 1'b0;
			pin_oe_n_r <= 1'b1;
		end
		else
		begin
			pin_o_r <= pwm_mode ? level : 1'b0;
			pin_oe_n_r <= !(pwm_mode && !pin_direction_r);
		end
	end

	// pin level as seen at the pad, kept for a future readback
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pin_seen_r <= 1'b0;
		else
			pin_seen_r <= pwm_pin_i;
	end

	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign pwm_pin_o = pin_o_r;
	assign pwm_pin_oe_n = pin_oe_n_r;

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence setup_s;
		psel && !penable;
	endsequence
	sequence wait_s;
		psel && penable && !pready_r;
	endsequence
	apb_answer_a: assert property (setup_s ##1 wait_s |=> pready_r ##1 !pready_r)
		else $error("apb answer not one clock after access start");
	pin_release_a: assert property (capture_pwm_control_r == 6'h00 |=> pin_oe_n_r)
		else $error("pin still driven with control cleared");
	pin_follow_a: assert property (pwm_mode && !pin_direction_r |=> !pin_oe_n_r && pin_o_r == $past(level))
		else $error("pin does not follow pwm level");
	flag_set_a: assert property (tb_if.restart |=> timer_match_flag_r)
		else $error("match flag lost at restart");
	duty_hold_a: assert property (wr && paddr == OFF_DUTY_UPPER && !tb_if.restart |=> $stable(shadow))
		else $error("duty write reached shadow mid period");
endmodule
`default_nettype wire

//--- verif/spwm_load.sv
// Purpose: external load on the pwm pin, measures each pulse
// Assumes: pad has a weak pull-down when the pin is released
// Notes: after an arm pulse it reports two whole periods, then idles
`timescale 1ns/10ps
`default_nettype none
module spwm_load
(
	input wire logic pclk,
	input wire logic pin_o,
	input wire logic pin_oe_n,
	input wire logic arm,
	output logic pad,
	output logic meas_v,
	output logic [15:0] per,
	output logic [15:0] hi
);
	logic prev = 1'b0;
	logic seen = 1'b0;
	logic [1:0] left = 2'h0;
	logic [15:0] pc = 16'h0;
	logic [15:0] hc = 16'h0;
	// released pin floats to the pull-down, never to the last driven level
	assign pad = pin_oe_n ? 1'b0 : pin_o;
	// rising edge to rising edge gives the period, high cycles the width
	always @(posedge pclk)
	begin
		meas_v <= 1'b0;
		prev <= pad;
		if (arm)
		begin
			left <= 2'h2;
			seen <= 1'b0;
		end
		else if (pad && !prev)
		begin
			if (seen && left != 2'h0)
			begin
				meas_v <= 1'b1;
				per <= pc;
				hi <= hc;
				left <= left - 2'h1;
			end
			seen <= 1'b1;
			pc <= 16'h1;
			hc <= 16'h1;
		end
		else
		begin
			pc <= pc + 16'h1;
			hc <= hc + {15'h0, pad};
		end
	end
endmodule
`default_nettype wire

//--- verif/standard_pwm_output_tb.sv
// Purpose: self-checking bench for the standard pwm block
// Assumes: apb answer is awaited on pready, one access at a time
// Notes: expected words and pulse counts wait in queues for the monitor
`timescale 1ns/10ps
`default_nettype none
module standard_pwm_output_tb;
	import spwm_pkg::*;
	typedef struct packed {logic rd; logic er; logic [31:0] d;} spwm_note_s;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, sleep_i = 0, arm = 0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, seed = 32'hc93da9a7;
	logic pready, pslverr, pin_o, oe_n, pad, meas_v;
	logic [15:0] per, hi;
	spwm_note_s nq[$];
	spwm_note_s nt;
	logic [15:0] pq[$], hq[$];
	int num_errors = 0, checked = 0, lim, duty, ratio, plen;
	spwm_top dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .sleep_i(sleep_i), .pwm_pin_i(pad), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.pwm_pin_o(pin_o), .pwm_pin_oe_n(oe_n));
	spwm_load load (.pclk(pclk), .pin_o(pin_o), .pin_oe_n(oe_n), .arm(arm), .pad(pad), .meas_v(meas_v),
		.per(per), .hi(hi));
	// 50 MHz oscillator
	initial
	begin
		forever #10 pclk = ~pclk;
	end
	function automatic logic [31:0] xs(input logic [31:0] s);
		logic [31:0] t;
		t = s ^ (s << 13);
		t = t ^ (t >> 17);
		return t ^ (t << 5);
	endfunction
	task automatic cmp_word(input string what, input logic [31:0] exp, input logic [31:0] got);
		checked++;
		if (got !== exp)
		begin
			num_errors++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic close_out();
		if (num_errors == 0 && checked > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge pclk);
	endtask
	// one apb transfer; d is write data, or the expected word on a read
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d, input logic er);
		int n;
		n = 0;
		nq.push_back({~w, er, d});
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 40);
		if (n >= 40)
			num_errors++;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic reset_regs();
		logic [7:0] offs [8];
		logic [31:0] vals [8];
		offs = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c};
		vals = '{32'h0, 32'hff, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h1};
		for (int i = 0; i < 8; i++)
			apb(offs[i], 1'b0, vals[i], 1'b0);
	endtask
	task automatic level_run(input int n, input logic [31:0] exp, input string what);
		int c;
		c = 0;
		repeat (n)
		begin
			@(posedge pclk);
			c += (pin_o === 1'b1);
		end
		cmp_word(what, exp, 32'(c));
	endtask
	// monitor: each answer or measurement takes the oldest note
	always @(posedge pclk)
	begin
		if (pready === 1'b1)
		begin
			nt = nq.pop_front();
			cmp_word("pslverr", {31'h0, nt.er}, {31'h0, pslverr});
			if (nt.rd)
				cmp_word("prdata", nt.d, prdata);
		end
		if (meas_v === 1'b1)
		begin
			cmp_word("period", {16'h0, pq.pop_front()}, {16'h0, per});
			cmp_word("high", {16'h0, hq.pop_front()}, {16'h0, hi});
		end
	end
	// watchdog sized well past the longest sequence
	initial
	begin
		repeat (60000) @(posedge pclk);
		num_errors++;
		close_out();
	end
	initial
	begin
		tick(5);
		presetn <= 1'b1;
		@(posedge pclk);
		reset_regs();
		apb(8'h20, 1'b0, 32'h0, 1'b1);
		apb(8'h24, 1'b1, 32'h5, 1'b1);
		seed = xs(seed);
		lim = 4 + seed[2:0];
		apb(OFF_PIN_DIRECTION, 1'b1, 32'h1, 1'b0);
		apb(OFF_PERIOD_LIMIT, 1'b1, 32'(lim), 1'b0);
		// every prescale code, random duty inside the period
		for (int i = 0; i < 4; i++)
		begin
			ratio = (i == 0) ? 1 : (i == 1) ? 4 : 16;
			plen = (lim + 1) * 4 * ratio;
			seed = xs(seed);
			duty = 1 + seed % (4 * lim + 3);
			apb(OFF_PIN_DIRECTION, 1'b1, 32'h1, 1'b0);
			apb(OFF_DUTY_UPPER, 1'b1, 32'(duty >> 2), 1'b0);
			apb(OFF_CAPTURE_PWM_CONTROL, 1'b1, 32'(((duty & 3) << 4) | 12), 1'b0);
			apb(OFF_PERIPHERAL_FLAG, 1'b1, 32'h2, 1'b0);
			apb(OFF_TIMER_CONTROL, 1'b1, 32'(4 + i), 1'b0);
			tick(2 * plen + 8);
			apb(OFF_PERIPHERAL_FLAG, 1'b0, 32'h2, 1'b0);
			apb(OFF_DUTY_SHADOW, 1'b0, 32'(duty >> 2), 1'b0);
			apb(OFF_DUTY_SHADOW, 1'b1, 32'(~(duty >> 2) & 255), 1'b0);
			apb(OFF_DUTY_SHADOW, 1'b0, 32'(duty >> 2), 1'b0);
			apb(OFF_PERIPHERAL_FLAG, 1'b1, 32'h2, 1'b0);
			apb(OFF_PIN_DIRECTION, 1'b1, 32'h0, 1'b0);
			tick(4);
			arm <= 1'b1;
			repeat (2)
			begin
				pq.push_back(16'(plen));
				hq.push_back(16'(duty * ratio));
			end
			@(posedge pclk);
			arm <= 1'b0;
			tick(3 * plen + 8);
		end
		// duty at both ends of the range
		apb(OFF_TIMER_CONTROL, 1'b1, 32'h4, 1'b0);
		plen = (lim + 1) * 4;
		apb(OFF_DUTY_UPPER, 1'b1, 32'h0, 1'b0);
		apb(OFF_CAPTURE_PWM_CONTROL, 1'b1, 32'hc, 1'b0);
		tick(2 * plen + 8);
		level_run(2 * plen, 32'h0, "zero duty high cycles");
		apb(OFF_DUTY_UPPER, 1'b1, 32'(lim + 1), 1'b0);
		tick(2 * plen + 8);
		level_run(2 * plen, 32'(2 * plen), "full duty high cycles");
		// sleep freezes a mid duty waveform at its present level
		apb(OFF_DUTY_UPPER, 1'b1, 32'((lim + 1) / 2), 1'b0);
		tick(2 * plen + plen / 4);
		sleep_i <= 1'b1;
		tick(2);
		level_run(2 * plen, pin_o ? 32'(2 * plen) : 32'h0, "sleep high cycles");
		sleep_i <= 1'b0;
		// clearing the whole control register hands the pin back
		apb(OFF_CAPTURE_PWM_CONTROL, 1'b1, 32'h0, 1'b0);
		tick(3);
		cmp_word("released enable", 32'h1, {31'h0, oe_n});
		cmp_word("released level", 32'h0, {31'h0, pin_o});
		presetn <= 1'b0;
		@(posedge pclk);
		cmp_word("reset enable", 32'h1, {31'h0, oe_n});
		presetn <= 1'b1;
		@(posedge pclk);
		reset_regs();
		tick(4);
		if (nq.size() != 0 || pq.size() != 0)
			num_errors++;
		close_out();
	end
endmodule
`default_nettype wire
